// File: logic/cta_pkg.sv
// constants, field layout and state type of the cache test access block
package cta_pkg;
  // register selects on the core's test register move port
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_STATUS = 2'h1;
  localparam logic [1:0] SEL_CTRL = 2'h2;
  // control field encodings
  localparam logic [1:0] OP_BUF = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_FLUSH = 2'h3;
  // control register field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_ENTRY_LSB = 2;
  localparam int CTRL_SET_LSB = 4;
  // tag/status register field positions
  localparam int TS_TAG_LSB = 11;
  localparam int TS_VALID_BIT = 10;
  localparam int TS_LRU_LSB = 7;
  localparam int TS_SETVALID_LSB = 3;
  // geometry
  localparam int SETS = 128;
  localparam int WAYS = 4;
  localparam int SET_W = 7;
  localparam int ENTRY_W = 2;
  localparam int TAG_W = 21;
  localparam int LRU_W = 3;
  localparam int WORD_W = 32;
  localparam int LINE_W = 128;
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  typedef enum logic {CTA_IDLE, CTA_EXEC} cta_state_t;
endpackage

// File: logic/cta_cache_test_access.sv
// test register access path into the unified cache arrays and buffers
//
// Summary of operation
// - control field 00 makes entry select pick one buffer word of four.
// - data window write with field 00 stores word into chosen fill buffer slot.
// - control field 01 writes fill buffer, tag and valid into addressed entry.
// - for write and read, set select picks set, entry select picks way.
// - test write updates set LRU bits through the normal LRU update logic.
// - control field 10 with set and entry starts read into read buffer.
// - test read loads status with tag, valid, set LRU and set valids.
// - test read loads read buffer with the full 128-bit data line.
// - data window read with field 00 returns chosen read buffer word.
// - memory accesses overwrite the read buffer; software drains it first.
// - control field 11 flushes; all other control fields are ignored then.
// - flush clears all LRU and valid bits, tags and data untouched.
// - control register flush raises no external flush bus cycle.
// - seven-bit set select addresses 128 sets of four entries.
// - 32-bit data window is the only core access path to the 128-bit buffers.
`timescale 1ns/1ps
module cta_cache_test_access #(
  parameter int SETS = cta_pkg::SETS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] treg_sel,
  input wire logic treg_wr,
  input wire logic treg_rd,
  input wire logic [31:0] treg_wdata,
  output logic treg_ready,
  output logic [31:0] treg_rdata,
  output logic treg_rvalid,
  input wire logic mem_ref_strobe,
  input wire logic [127:0] mem_ref_line,
  input wire logic ext_flush_req,
  output logic flush_cycle_req
);

  cta_pkg::cta_state_t state_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] status_reg;
  logic [31:0] fill_buf [0:cta_pkg::WAYS-1];
  logic [cta_pkg::LINE_W-1:0] read_buf_reg;
  logic [cta_pkg::LINE_W-1:0] data_arr [0:SETS*cta_pkg::WAYS-1];
  logic [cta_pkg::TAG_W-1:0] tag_arr [0:SETS*cta_pkg::WAYS-1];
  logic [cta_pkg::WAYS-1:0] valid_arr [0:SETS-1];
  logic [cta_pkg::LRU_W-1:0] lru_arr [0:SETS-1];

  logic [1:0] op;
  logic [cta_pkg::ENTRY_W-1:0] entry;
  logic [cta_pkg::SET_W-1:0] set_sel;
  logic [cta_pkg::SET_W+cta_pkg::ENTRY_W-1:0] line_idx;
  logic take_wr;
  logic take_rd;
  logic start_op;
  logic exec_write;
  logic exec_read;
  logic do_flush;
  logic [cta_pkg::LINE_W-1:0] fill_line;
  logic [31:0] read_status;

  // control register fields steer every operation
  assign op = ctrl_reg[cta_pkg::CTRL_OP_LSB +: 2];
  assign entry = ctrl_reg[cta_pkg::CTRL_ENTRY_LSB +: cta_pkg::ENTRY_W];
  assign set_sel = ctrl_reg[cta_pkg::CTRL_SET_LSB +: cta_pkg::SET_W];
  assign line_idx = {set_sel, entry};

  // accesses are taken only while idle, so a triggered op always completes first
  assign treg_ready = (state_reg == cta_pkg::CTA_IDLE);
  assign take_wr = treg_wr && treg_ready;
  assign take_rd = treg_rd && !treg_wr && treg_ready;
  assign start_op = take_wr && (treg_sel == cta_pkg::SEL_CTRL) &&
                    (treg_wdata[cta_pkg::CTRL_OP_LSB +: 2] != cta_pkg::OP_BUF);
  assign exec_write = (state_reg == cta_pkg::CTA_EXEC) && (op == cta_pkg::OP_WRITE);
  assign exec_read = (state_reg == cta_pkg::CTA_EXEC) && (op == cta_pkg::OP_READ);
  // flush looks at nothing but the EXEC state, the op field and the external flush request
  assign do_flush = ((state_reg == cta_pkg::CTA_EXEC) && (op == cta_pkg::OP_FLUSH)) || ext_flush_req;

  // word 0 of the fill buffer sits in the low bits of the line
  assign fill_line = {fill_buf[3], fill_buf[2], fill_buf[1], fill_buf[0]};

  // status image of the addressed entry and its set
  assign read_status = {tag_arr[line_idx], valid_arr[set_sel][entry], lru_arr[set_sel],
                        valid_arr[set_sel], 3'h0};

  // pseudo-LRU tree: bit 0 names the pair not last used, bits 1 and 2 the way not last used in each pair
  function automatic logic [cta_pkg::LRU_W-1:0] lru_touch(
    input logic [cta_pkg::LRU_W-1:0] cur,
    input logic [cta_pkg::ENTRY_W-1:0] way
  );
    logic [cta_pkg::LRU_W-1:0] nxt;
    nxt = cur;
    nxt[0] = ~way[1];
    if (way[1] == 1'b0) begin
      nxt[1] = ~way[0];
    end else begin
      nxt[2] = ~way[0];
    end
    return nxt;
  endfunction

  // one extra cycle for any triggered operation
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= cta_pkg::CTA_IDLE;
    end else begin
      unique case (state_reg)
        cta_pkg::CTA_IDLE: begin
          if (start_op) begin
            state_reg <= cta_pkg::CTA_EXEC;
          end
        end
        cta_pkg::CTA_EXEC: begin
          state_reg <= cta_pkg::CTA_IDLE;
        end
      endcase
    end
  end

  // control register, plain storage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= cta_pkg::CTRL_RESET;
    end else if (take_wr && (treg_sel == cta_pkg::SEL_CTRL)) begin
      ctrl_reg <= treg_wdata;
    end
  end

  // tag/status register: software stages it, a test read overwrites it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= cta_pkg::STATUS_RESET;
    end else if (exec_read) begin
      status_reg <= read_status;
    end else if (take_wr && (treg_sel == cta_pkg::SEL_STATUS)) begin
      status_reg <= treg_wdata;
    end
  end

  // fill buffer loaded one word at a time through the data window
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < cta_pkg::WAYS; i++) begin
        fill_buf[i] <= 32'h0000_0000;
      end
    end else if (take_wr && (treg_sel == cta_pkg::SEL_DATA) && (op == cta_pkg::OP_BUF)) begin
      fill_buf[entry] <= treg_wdata;
    end
  end

  // read buffer shares the line path with memory traffic, so memory refs clobber it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_buf_reg <= '0;
    end else if (exec_read) begin
      read_buf_reg <= data_arr[line_idx];
    end else if (mem_ref_strobe) begin
      read_buf_reg <= mem_ref_line;
    end
  end

  // tag and data arrays: no reset, flush leaves them alone
  always_ff @(posedge sys_clk) begin
    if (exec_write) begin
      data_arr[line_idx] <= fill_line;
      tag_arr[line_idx] <= status_reg[cta_pkg::TS_TAG_LSB +: cta_pkg::TAG_W];
    end
  end

  // valid and LRU state: flush clears all of it, a test write updates one set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < SETS; s++) begin
        valid_arr[s] <= '0;
        lru_arr[s] <= '0;
      end
    end else if (do_flush) begin
      for (int s = 0; s < SETS; s++) begin
        valid_arr[s] <= '0;
        lru_arr[s] <= '0;
      end
    end else if (exec_write) begin
      valid_arr[set_sel][entry] <= status_reg[cta_pkg::TS_VALID_BIT];
      lru_arr[set_sel] <= lru_touch(lru_arr[set_sel], entry);
    end
  end

  // external flush cycle only for the instruction path, never for a test flush
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flush_cycle_req <= 1'b0;
    end else begin
      flush_cycle_req <= ext_flush_req;
    end
  end

  // read answer registered one cycle after the move is taken
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      treg_rdata <= cta_pkg::RDATA_RESET;
      treg_rvalid <= 1'b0;
    end else begin
      treg_rvalid <= take_rd;
      if (take_rd) begin
        unique case (treg_sel)
          cta_pkg::SEL_DATA: begin
            // words only visible with field 00; other modes read as zero
            if (op == cta_pkg::OP_BUF) begin
              treg_rdata <= read_buf_reg[{entry, 5'h00} +: cta_pkg::WORD_W];
            end else begin
              treg_rdata <= 32'h0000_0000;
            end
          end
          cta_pkg::SEL_STATUS: begin
            treg_rdata <= status_reg;
          end
          cta_pkg::SEL_CTRL: begin
            treg_rdata <= ctrl_reg;
          end
          default: begin
            treg_rdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule

// File: tb/cta_assertions.sv
// port assertions for the cache test access block
`timescale 1ns/1ps
module cta_checker #(
  parameter int SETS = 128
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] treg_sel,
  input wire logic treg_wr,
  input wire logic treg_rd,
  input wire logic [31:0] treg_wdata,
  input wire logic treg_ready,
  input wire logic [31:0] treg_rdata,
  input wire logic treg_rvalid,
  input wire logic mem_ref_strobe,
  input wire logic [127:0] mem_ref_line,
  input wire logic ext_flush_req,
  input wire logic flush_cycle_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic take_rd;
  logic take_op;
  // moves count only while ready; a write beats a read
  assign take_rd = treg_ready && treg_rd && !treg_wr;
  assign take_op = treg_ready && treg_wr && treg_sel == 2'h2;
  AST_RD_ANSWER: assert property (take_rd |=> treg_rvalid) else $error("read unanswered");
  AST_RV_CAUSE: assert property (!take_rd |=> !treg_rvalid) else $error("stray rvalid");
  AST_OP_BUSY: assert property (take_op && treg_wdata[1:0] != 2'h0 |=> !treg_ready ##1 treg_ready)
    else $error("busy not one cycle");
  AST_BUF_FREE: assert property (take_op && treg_wdata[1:0] == 2'h0 |=> treg_ready) else $error("busy");
  AST_RDATA_HOLD: assert property (!treg_rvalid |-> $stable(treg_rdata)) else $error("rdata moved");
  AST_UNMAPPED: assert property (take_rd && treg_sel == 2'h3 |=> treg_rdata == 32'h0) else $error("unmapped");
  AST_CTRL_NO_CYCLE: assert property (flush_cycle_req |-> $past(ext_flush_req)) else $error("flush cycle");
  AST_EXT_CYCLE: assert property (ext_flush_req |=> flush_cycle_req) else $error("no flush cycle");
  cover property (take_op && treg_wdata[1:0] == 2'h1);
  cover property (take_op && treg_wdata[1:0] == 2'h2);
  cover property (take_op && treg_wdata[1:0] == 2'h3);
endmodule
bind cta_cache_test_access cta_checker #(.SETS(SETS)) u_chk (.sys_clk, .rst_n, .treg_sel, .treg_wr, .treg_rd,
  .treg_wdata, .treg_ready, .treg_rdata, .treg_rvalid, .mem_ref_strobe, .mem_ref_line, .ext_flush_req,
  .flush_cycle_req);

// File: tb/cta_core_model.sv
// processor core model issuing test register moves
`timescale 1ns/1ps
module cta_core_model (
  input wire logic sys_clk,
  input wire logic treg_ready,
  input wire logic [31:0] treg_rdata,
  input wire logic treg_rvalid,
  output logic [1:0] treg_sel,
  output logic treg_wr,
  output logic treg_rd,
  output logic [31:0] treg_wdata,
  output logic tout
);
  initial begin
    {treg_sel, treg_wr, treg_rd, treg_wdata, tout} = '0;
  end
  // hold the move until an edge sees ready, then release
  task automatic mv(input logic w, input logic [1:0] s, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    {treg_wr, treg_rd, treg_sel, treg_wdata} = {w, ~w, s, d};
    @(posedge sys_clk);
    while (treg_ready !== 1'b1 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    tout = n >= 20;
    #1;
    // released qualifiers must not keep their last value
    {treg_wr, treg_rd, treg_sel, treg_wdata} = {2'h0, ~s, ~d};
    q = treg_rvalid === 1'b1 ? treg_rdata : 'x;
  endtask
endmodule

// File: tb/cache_test_access_test.sv
// self-checking bench for the cache test access block
`timescale 1ns/1ps
module cache_test_access_test;
  logic sys_clk, rst_n, treg_wr, treg_rd, treg_ready, treg_rvalid, mem_ref_strobe, ext_flush_req, flush_cycle_req;
  logic [1:0] treg_sel;
  logic [31:0] treg_wdata, treg_rdata, q;
  logic [127:0] mem_ref_line;
  logic [127:0] line [4];
  logic [31:0] tag_st [4];
  logic [10:0] loc [4];
  int err_total = 0;
  int checks = 0;
  cta_cache_test_access i_dut (.sys_clk, .rst_n, .treg_sel, .treg_wr, .treg_rd, .treg_wdata, .treg_ready,
    .treg_rdata, .treg_rvalid, .mem_ref_strobe, .mem_ref_line, .ext_flush_req, .flush_cycle_req);
  cta_core_model u_core (.sys_clk, .treg_ready, .treg_rdata, .treg_rvalid, .treg_sel, .treg_wr, .treg_rd,
    .treg_wdata, .tout());
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // a stuck ready ends the run
  task automatic mv(input logic w, input logic [1:0] s, input logic [31:0] d);
    u_core.mv(w, s, d, q);
    if (u_core.tout) begin
      err_total++;
      close_out();
    end
  endtask
  // drain four read buffer words before any memory reference
  task automatic drain(input logic [127:0] exp);
    for (int k = 0; k < 4; k++) begin
      mv(1'b1, 2'h2, 32'(k) << 2);
      mv(1'b0, 2'h0, 32'h0);
      chk("word", exp[32*k+:32], q);
    end
  endtask
  // status after one write into a fresh set: tag, valid, lru, set valids
  function automatic logic [31:0] stat(input logic [31:0] ts, input logic [1:0] w);
    return {ts[31:10], w[1] ? {~w[0], 2'h0} : {1'b0, ~w[0], 1'b1}, 4'(ts[10]) << w, 3'h0};
  endfunction
  initial begin
    {rst_n, mem_ref_strobe, ext_flush_req, mem_ref_line} = '0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    void'($urandom(32'h065E120B));
    // location 1 (random entry in set group 1) is written invalid as a corner
    for (int i = 0; i < 4; i++) begin
      loc[i] = {2'(i), 5'($urandom), 2'($urandom), 2'h0};
      tag_st[i] = {21'($urandom), 1'(i != 1), 10'h0};
      line[i] = {$urandom, $urandom, $urandom, $urandom};
      for (int k = 0; k < 4; k++) begin
        mv(1'b1, 2'h2, 32'(k) << 2);
        mv(1'b1, 2'h0, line[i][32*k+:32]);
      end
      mv(1'b1, 2'h1, tag_st[i]);
      mv(1'b1, 2'h2, {21'h0, loc[i] | 11'h1});
    end
    for (int i = 0; i < 4; i++) begin
      mv(1'b1, 2'h2, {21'h0, loc[i] | 11'h2});
      mv(1'b0, 2'h1, 32'h0);
      chk("status", stat(tag_st[i], loc[i][3:2]), q);
      drain(line[i]);
    end
    // a memory reference overwrites the read buffer
    @(posedge sys_clk);
    #1;
    {mem_ref_line, mem_ref_strobe} = {$urandom, $urandom, $urandom, $urandom, 1'b1};
    @(posedge sys_clk);
    #1;
    mem_ref_strobe = 1'b0;
    drain(mem_ref_line);
    mv(1'b0, 2'h3, 32'h0);
    chk("unmapped", 32'h0, q);
    mv(1'b1, 2'h2, $urandom | 32'h3);
    mv(1'b1, 2'h2, {21'h0, loc[0] | 11'h2});
    // a test flush must not raise the external flush cycle; sampled once, two cycles after the flush write
    chk("ctrl flush cycle", 32'h0, {31'h0, flush_cycle_req});
    mv(1'b0, 2'h1, 32'h0);
    chk("flushed", {tag_st[0][31:11], 11'h0}, q);
    drain(line[0]);
    @(posedge sys_clk);
    #1;
    ext_flush_req = 1'b1;
    @(posedge sys_clk);
    #1;
    ext_flush_req = 1'b0;
    chk("flush cycle", 32'h1, {31'h0, flush_cycle_req});
    close_out();
  end
endmodule
